//--- core/mlc_defs.svh
// offsets, field positions, reset values and counts of the modem line control
`ifndef MLC_DEFS_SVH
`define MLC_DEFS_SVH
`define MLC_OFS_CTRL 8'h00
`define MLC_OFS_STAT 8'h04
`define MLC_OFS_MASK 8'h08
`define MLC_OFS_PINS 8'h0C
`define MLC_CTRL_RST 8'h00
`define MLC_BIT_CLKSEL 7
`define MLC_BIT_IREN 6
`define MLC_BIT_XANY 5
`define MLC_BIT_LOOP 4
`define MLC_BIT_IRQOE 3
`define MLC_BIT_UOUT1 2
`define MLC_ST_MODEM 0
`define MLC_ST_XON 1
`define MLC_ST_RST 2'h0
`define MLC_MASK_RST 2'h0
`define MLC_PRE_DIV 16
`define MLC_CLK_DIV 4
`endif

//--- core/mlc_pkg.sv
// types shared by the modem line control logic
package mlc_pkg;
    typedef logic [7:0] ctrl_t;
    typedef logic [1:0] irq_t;
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_HALF = 2'h1,
        WR_RESP = 2'h3
    } wr_state_t;
endpackage : mlc_pkg

//--- core/uart_modem_line_control.sv
// modem line control register of one uart channel with axi4-lite access
// What this block does
// - clock select clear: input clock divided by sixteen feeds baud generator
// - clock select set: the divided clock is further divided by four
// - infrared enable routes serial transmit and receive through ir codec
// - in infrared mode the ir transmit output stays low while idle
// - resume-on-any makes any received character a resume condition
// - loop-back detaches serial and modem pins and loops signals inside
// - receiver and transmitter interrupts work unchanged in loop-back
// - loop-back modem interrupts come from internal outputs, still enable-gated
// - irq enable bit clear floats the four channel irq outputs, set drives
// - loop-back carrier detect is the inverse of the irq enable bit
// - user output one acts only in loop-back, setting ring indicator
// - reset clears clock select, infrared, resume-any, loop-back, irq enable
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "mlc_defs.svh"
module uart_modem_line_control #(
    parameter int PRE_DIV = `MLC_PRE_DIV,
    parameter int CLK_DIV = `MLC_CLK_DIV
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // internal uart side, same clock
    input wire logic tx_serial,
    input wire logic rts_int,
    input wire logic dtr_int,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic [7:0] xon_char,
    input wire logic modem_irq_en,
    input wire logic [3:0] chan_irq_req,
    output logic baud_tick,
    output logic rx_serial,
    output logic cts_int,
    output logic dsr_int,
    output logic cd_int,
    output logic ri_int,
    output logic modem_event,
    output logic xon_resume,
    // pins
    output logic tx_pin,
    output logic ir_tx_pin,
    input wire logic rx_pin,
    input wire logic ir_rx_pin,
    input wire logic cts_pin,
    input wire logic dsr_pin,
    input wire logic cd_pin,
    input wire logic ri_pin,
    output logic [3:0] channel_irq_outputs,
    output logic [3:0] channel_irq_oe,
    // interrupt
    output logic irq
);
    localparam logic [3:0] PRE_LAST = 4'(PRE_DIV - 1);
    localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);

    mlc_pkg::ctrl_t modem_line_control_q, modem_line_control_d;
    mlc_pkg::irq_t stat_q, stat_d, mask_q, mask_d;
    mlc_pkg::wr_state_t wst_q, wst_d;
    logic [7:0] waddr_q, waddr_d;
    logic [7:0] wdat_q, wdat_d;
    logic wbe_q, wbe_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

    // pin synchronisers: stage one is read only by stage two
    logic [5:0] sync1_q, sync2_q;
    logic [5:0] pins_raw;
    assign pins_raw = {ri_pin, cd_pin, dsr_pin, cts_pin, ir_rx_pin, rx_pin};

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `MLC_OFS_CTRL) || (a == `MLC_OFS_STAT) ||
                 (a == `MLC_OFS_MASK) || (a == `MLC_OFS_PINS);
    endfunction : mapped

    logic loop, ir_en;
    assign loop = modem_line_control_q[`MLC_BIT_LOOP];
    assign ir_en = modem_line_control_q[`MLC_BIT_IREN];

    // prescaler
    logic [3:0] pre_q, pre_d;
    logic [1:0] div_q, div_d;
    logic tick_q, tick_d;
    logic pre_wrap;
    assign pre_wrap = (pre_q == PRE_LAST);

    always_comb begin
        pre_d = pre_wrap ? 4'h0 : pre_q + 4'h1;
        div_d = div_q;
        if (pre_wrap) begin
            div_d = (div_q == DIV_LAST) ? 2'h0 : div_q + 2'h1;
        end
        if (modem_line_control_q[`MLC_BIT_CLKSEL]) begin
            tick_d = pre_wrap && (div_q == DIV_LAST);
        end else begin
            tick_d = pre_wrap;
        end
    end

    // line and modem path
    logic rxs_d, cts_d, dsr_d, cd_d, ri_d, txp_d, irp_d;
    logic rxs_q, cts_q, dsr_q, cd_q, ri_q, txp_q, irp_q;
    logic [3:0] mprev_q, mprev_d;
    logic mev_q, mev_d, xon_q, xon_d;
    logic [3:0] cio_q, cio_d, coe_q, coe_d;
    logic irq_q, irq_d;
    logic modem_chg, xon_hit;

    always_comb begin
        if (loop) begin
            rxs_d = tx_serial;
            txp_d = 1'b1;
            irp_d = 1'b0;
            cts_d = rts_int;
            dsr_d = dtr_int;
            cd_d = ~modem_line_control_q[`MLC_BIT_IRQOE];
            ri_d = ~modem_line_control_q[`MLC_BIT_UOUT1];
        end else begin
            // ir decoder: a light pulse arrives as a high level
            rxs_d = ir_en ? ~sync2_q[1] : sync2_q[0];
            txp_d = ir_en ? 1'b1 : tx_serial;
            irp_d = ir_en & ~tx_serial;
            cts_d = sync2_q[2];
            dsr_d = sync2_q[3];
            cd_d = sync2_q[4];
            ri_d = sync2_q[5];
        end
        mprev_d = {ri_q, cd_q, dsr_q, cts_q};
        // ring counts only on its falling edge
        modem_chg = (mprev_q[2:0] != {cd_q, dsr_q, cts_q}) ||
                    (mprev_q[3] & ~ri_q);
        mev_d = modem_chg & modem_irq_en;
        xon_hit = rx_char_valid &&
            (modem_line_control_q[`MLC_BIT_XANY] || rx_char == xon_char);
        xon_d = xon_hit;
        cio_d = chan_irq_req;
        coe_d = {4{modem_line_control_q[`MLC_BIT_IRQOE]}};
        irq_d = |(stat_q & mask_q);
    end

    // register file and axi4-lite slave
    always_comb begin
        modem_line_control_d = modem_line_control_q;
        mask_d = mask_q;
        // set wins over a write-one clear in the same cycle
        stat_d = stat_q;
        wst_d = wst_q;
        waddr_d = waddr_q;
        wdat_d = wdat_q;
        wbe_d = wbe_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            waddr_d = s_axi_awaddr;
            aw_got_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdat_d = s_axi_wdata[7:0];
            wbe_d = s_axi_wstrb[0];
            w_got_d = 1'b1;
        end
        unique case (wst_q)
            mlc_pkg::WR_IDLE, mlc_pkg::WR_HALF: begin
                if (aw_got_q && w_got_q) begin
                    if (wbe_q && waddr_q == `MLC_OFS_CTRL) begin
                        modem_line_control_d = wdat_q;
                    end
                    if (wbe_q && waddr_q == `MLC_OFS_MASK) begin
                        mask_d = wdat_q[1:0];
                    end
                    if (wbe_q && waddr_q == `MLC_OFS_STAT) begin
                        stat_d = stat_q & ~wdat_q[1:0];
                    end
                    bresp_d = mapped(waddr_q) ? 2'h0 : 2'h2;
                    bvalid_d = 1'b1;
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = mlc_pkg::WR_RESP;
                end else if (aw_got_q || w_got_q) begin
                    wst_d = mlc_pkg::WR_HALF;
                end
            end
            mlc_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wst_d = mlc_pkg::WR_IDLE;
                end
            end
            default: wst_d = mlc_pkg::WR_IDLE;
        endcase
        if (mev_q) begin
            stat_d[`MLC_ST_MODEM] = 1'b1;
        end
        if (xon_q) begin
            stat_d[`MLC_ST_XON] = 1'b1;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            unique case (s_axi_araddr)
                `MLC_OFS_CTRL: rdata_d = {24'h0, modem_line_control_q};
                `MLC_OFS_STAT: rdata_d = {30'h0, stat_q};
                `MLC_OFS_MASK: rdata_d = {30'h0, mask_q};
                `MLC_OFS_PINS: rdata_d = {26'h0, sync2_q};
                default: rdata_d = 32'h0;
            endcase
        end
        // readies registered so every bus output leaves a flip-flop
        awready_d = ~aw_got_d & ~bvalid_d;
        wready_d = ~w_got_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_line_control_q <= `MLC_CTRL_RST;
            stat_q <= `MLC_ST_RST;
            mask_q <= `MLC_MASK_RST;
            wst_q <= mlc_pkg::WR_IDLE;
            waddr_q <= 8'h00;
            wdat_q <= 8'h00;
            wbe_q <= 1'b0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rresp_q <= 2'h0;
            rdata_q <= 32'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            sync1_q <= 6'h3F;
            sync2_q <= 6'h3F;
            pre_q <= 4'h0;
            div_q <= 2'h0;
            tick_q <= 1'b0;
            rxs_q <= 1'b1;
            cts_q <= 1'b1;
            dsr_q <= 1'b1;
            cd_q <= 1'b1;
            ri_q <= 1'b1;
            txp_q <= 1'b1;
            irp_q <= 1'b0;
            mprev_q <= 4'hF;
            mev_q <= 1'b0;
            xon_q <= 1'b0;
            cio_q <= 4'h0;
            coe_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            modem_line_control_q <= modem_line_control_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            wst_q <= wst_d;
            waddr_q <= waddr_d;
            wdat_q <= wdat_d;
            wbe_q <= wbe_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
            pre_q <= pre_d;
            div_q <= div_d;
            tick_q <= tick_d;
            rxs_q <= rxs_d;
            cts_q <= cts_d;
            dsr_q <= dsr_d;
            cd_q <= cd_d;
            ri_q <= ri_d;
            txp_q <= txp_d;
            irp_q <= irp_d;
            mprev_q <= mprev_d;
            mev_q <= mev_d;
            xon_q <= xon_d;
            cio_q <= cio_d;
            coe_q <= coe_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign baud_tick = tick_q;
    assign rx_serial = rxs_q;
    assign cts_int = cts_q;
    assign dsr_int = dsr_q;
    assign cd_int = cd_q;
    assign ri_int = ri_q;
    assign modem_event = mev_q;
    assign xon_resume = xon_q;
    assign tx_pin = txp_q;
    assign ir_tx_pin = irp_q;
    assign channel_irq_outputs = cio_q;
    assign channel_irq_oe = coe_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_tick_div16: assert property (
        !modem_line_control_q[`MLC_BIT_CLKSEL] && $rose(tick_q) |=>
        !tick_q [*8] ##8 (tick_q || modem_line_control_q[`MLC_BIT_CLKSEL]))
        else $error("divide-by-16 tick spacing wrong");
    a_tick_div4: assert property (
        modem_line_control_q[`MLC_BIT_CLKSEL] && tick_q |=> !tick_q [*8])
        else $error("divide-by-4 tick came too early");
    a_ir_route: assert property (
        ir_en && !loop |=> tx_pin)
        else $error("transmit pin not idle in ir mode");
    a_ir_idle: assert property (
        ir_en && !loop && tx_serial |=> !ir_tx_pin)
        else $error("ir transmit not low while idle");
    a_xon_any: assert property (
        modem_line_control_q[`MLC_BIT_XANY] && rx_char_valid |=> xon_resume)
        else $error("any character did not resume");
    a_loop_rx: assert property (
        loop && $stable(loop) |=> rx_serial == $past(tx_serial) && tx_pin)
        else $error("loop-back data path broken");
    a_loop_mev: assert property (
        !modem_irq_en |=> !modem_event)
        else $error("modem event not gated by enable");
    a_irq_oe: assert property (
        $past(modem_line_control_q[`MLC_BIT_IRQOE]) |->
        channel_irq_oe == 4'hF)
        else $error("irq outputs not driven");
    a_loop_cd: assert property (
        loop |=>
        cd_int == !$past(modem_line_control_q[`MLC_BIT_IRQOE]))
        else $error("loop carrier detect not inverse");
    a_loop_ri: assert property (
        loop |=>
        ri_int == !$past(modem_line_control_q[`MLC_BIT_UOUT1]))
        else $error("loop ring indicator wrong");
    a_wr_resp: assert property (
        aw_got_q && w_got_q && !bvalid_q |=> bvalid_q)
        else $error("write response missing");
    c_loop_xon: cover property (loop ##1 xon_resume);
    c_div4: cover property (modem_line_control_q[`MLC_BIT_CLKSEL] && tick_q);
    c_irq: cover property ($rose(irq));
endmodule : uart_modem_line_control

//--- sim/mlc_line_peer.sv
// far-side line partner: echoes the serial lines inverted, modem pins set
`timescale 1ns/100ps
module mlc_line_peer (
    // lines from the channel
    input wire logic tx_pin,
    input wire logic ir_tx_pin,
    // modem pin levels {ri, cd, dsr, cts} chosen by the bench
    input wire logic [3:0] mdm,
    // lines into the channel
    output logic rx_pin,
    output logic ir_rx_pin,
    output logic cts_pin,
    output logic dsr_pin,
    output logic cd_pin,
    output logic ri_pin
);
    // inverted echo, so a looped or detached path reads differently
    assign rx_pin = ~tx_pin;
    assign ir_rx_pin = ~ir_tx_pin;
    assign {ri_pin, cd_pin, dsr_pin, cts_pin} = mdm;
endmodule : mlc_line_peer

//--- sim/tb.sv
// self-checking bench of the modem line control register
`timescale 1ns/100ps
`include "mlc_defs.svh"
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, seen;
    logic [7:0] awaddr, araddr, rx_char, xon_char;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic tx_serial, rts_int, dtr_int, rx_char_valid, modem_irq_en;
    logic [3:0] chan_irq_req, mdm, ch_out, ch_oe;
    logic baud_tick, rx_serial, cts_int, dsr_int, cd_int, ri_int;
    logic modem_event, xon_resume, tx_pin, ir_tx_pin, rx_pin, ir_rx_pin;
    logic cts_pin, dsr_pin, cd_pin, ri_pin;
    int fails, check_count, cyc, n;
    typedef struct {logic [7:0] c; logic tx; logic rts; logic [6:0] ex;} row_t;
    row_t rows [6];

    uart_modem_line_control i_uart_modem_line_control (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .tx_serial(tx_serial), .rts_int(rts_int),
        .dtr_int(dtr_int), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .xon_char(xon_char),
        .modem_irq_en(modem_irq_en), .chan_irq_req(chan_irq_req),
        .baud_tick(baud_tick), .rx_serial(rx_serial), .cts_int(cts_int),
        .dsr_int(dsr_int), .cd_int(cd_int), .ri_int(ri_int),
        .modem_event(modem_event), .xon_resume(xon_resume),
        .tx_pin(tx_pin), .ir_tx_pin(ir_tx_pin), .rx_pin(rx_pin),
        .ir_rx_pin(ir_rx_pin), .cts_pin(cts_pin), .dsr_pin(dsr_pin),
        .cd_pin(cd_pin), .ri_pin(ri_pin), .channel_irq_outputs(ch_out),
        .channel_irq_oe(ch_oe), .irq(irq));

    mlc_line_peer i_mlc_line_peer (
        .tx_pin(tx_pin), .ir_tx_pin(ir_tx_pin), .mdm(mdm),
        .rx_pin(rx_pin), .ir_rx_pin(ir_rx_pin), .cts_pin(cts_pin),
        .dsr_pin(dsr_pin), .cd_pin(cd_pin), .ri_pin(ri_pin));

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    // whole run is about 500 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    // ready and response are looked at just before the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1'h1;
        pw = 1'h1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (pa || pw) begin
            @(negedge aclk);
            if (awready) pa = 1'h0;
            if (wready) pw = 1'h0;
            @(posedge aclk);
            awvalid <= pa;
            wvalid <= pw;
        end
        do @(negedge aclk); while (bvalid !== 1'h1);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'h0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge aclk); while (arready !== 1'h1);
        @(posedge aclk);
        arvalid <= 1'h0;
        do @(negedge aclk); while (rvalid !== 1'h1);
        rd = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'h0;
    endtask : rdr

    // second interval only: the first may straddle the divider change
    task automatic baud;
        repeat (2) begin
            do @(negedge aclk); while (baud_tick !== 1'h1);
            n = 0;
            do begin
                @(negedge aclk);
                n++;
            end while (baud_tick !== 1'h1);
        end
    endtask : baud

    task automatic rxc(input logic [7:0] c);
        @(posedge aclk);
        rx_char <= c;
        rx_char_valid <= 1'h1;
        @(posedge aclk);
        rx_char_valid <= 1'h0;
        seen = 1'h0;
        repeat (3) begin
            @(negedge aclk);
            seen = seen | xon_resume;
        end
    endtask : rxc

    task automatic settle(input int k);
        repeat (k) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, rx_char, rx_char_valid} = 57'h0;
        {rts_int, dtr_int, modem_irq_en, chan_irq_req, mdm} = 11'h000;
        tx_serial = 1'h1;
        xon_char = 8'h11;
        {fails, check_count, cyc} = 96'h0;
        // expected {tx_pin, ir_tx, rx_serial, cts, cd, ri, oe}
        rows[0] = '{8'h00, 1'h0, 1'h1, 7'b0010000};
        rows[1] = '{8'h40, 1'h0, 1'h1, 7'b1110000};
        rows[2] = '{8'h40, 1'h1, 1'h1, 7'b1000000};
        rows[3] = '{8'h10, 1'h0, 1'h1, 7'b1001110};
        rows[4] = '{8'h1C, 1'h1, 1'h0, 7'b1010001};
        rows[5] = '{8'h0C, 1'h1, 1'h1, 7'b1000001};
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(`MLC_OFS_CTRL);
        chk(rd, 32'h0);
        chk({ch_oe, tx_pin, irq}, 6'h02);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(`MLC_OFS_CTRL, {24'h0, rows[i].c});
            @(posedge aclk);
            tx_serial <= rows[i].tx;
            rts_int <= rows[i].rts;
            settle(6);
            chk({tx_pin, ir_tx_pin, rx_serial, cts_int, cd_int, ri_int,
                 &ch_oe}, rows[i].ex);
            chk(|ch_oe, rows[i].ex[0]);
        end
        $display("mode rows done");
        wr(`MLC_OFS_CTRL, 32'h0);
        baud();
        chk(n, 16);
        wr(`MLC_OFS_CTRL, 32'h80);
        baud();
        chk(n, 64);
        $display("baud test done");
        wr(`MLC_OFS_CTRL, 32'h0);
        rxc(8'h41);
        chk(seen, 1'h0);
        rxc(8'h11);
        chk(seen, 1'h1);
        wr(`MLC_OFS_CTRL, 32'h20);
        rxc(8'h41);
        chk(seen, 1'h1);
        $display("resume test done");
        wr(`MLC_OFS_CTRL, 32'h0);
        wr(`MLC_OFS_STAT, 32'h3);
        wr(`MLC_OFS_MASK, 32'h1);
        @(posedge aclk);
        modem_irq_en <= 1'h1;
        mdm <= 4'h4;
        settle(8);
        chk(irq, 1'h1);
        rdr(`MLC_OFS_STAT);
        chk(rd, 32'h1);
        wr(`MLC_OFS_MASK, 32'h0);
        settle(3);
        chk(irq, 1'h0);
        wr(`MLC_OFS_MASK, 32'h1);
        wr(`MLC_OFS_STAT, 32'h1);
        settle(3);
        chk(irq, 1'h0);
        @(posedge aclk);
        modem_irq_en <= 1'h0;
        mdm <= 4'h0;
        settle(8);
        rdr(`MLC_OFS_STAT);
        chk(rd, 32'h0);
        // loop-back: the event sources are the internal rts and dtr lines
        wr(`MLC_OFS_CTRL, 32'h10);
        wr(`MLC_OFS_STAT, 32'h3);
        @(posedge aclk);
        modem_irq_en <= 1'h1;
        rts_int <= 1'h0;
        dtr_int <= 1'h1;
        chan_irq_req <= 4'hA;
        seen = 1'h0;
        repeat (6) begin
            @(negedge aclk);
            seen = seen | modem_event;
        end
        chk(seen, 1'h1);
        chk(ch_out, 4'hA);
        chk({cts_int, dsr_int}, 2'h1);
        rdr(`MLC_OFS_STAT);
        chk(rd, 32'h1);
        $display("interrupt test done");
        rdr(8'h10);
        chk(rd, 32'h0);
        chk(rs, 2'h2);
        wr(8'h10, 32'hFF);
        chk(rs, 2'h2);
        wr(`MLC_OFS_CTRL, 32'hFF);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(`MLC_OFS_CTRL);
        chk(rd, 32'h0);
        chk(ch_oe, 4'h0);
        $display("bus and second reset test done");
        end_of_test();
    end
endmodule : tb
